// ### rtl/serg_defs.svh
// Purpose: Constants for the status event register group.
// Assumes: Included by serg_pkg and by the design modules.
// Notes:   Part selector codes act as the register offsets.
//
// Behaviour
// - A read of any status part returns its 15-bit value, 0 to 32767.
// - Writes to transition and enable parts take 0 to 32767 and steer events.
// - The instrument reset command leaves every status part unchanged.
// - The condition part mirrors the live inputs and is not cleared by reads.
// - Each set enable bit lets its event bit feed the summary bit.
// - The event part accumulates qualified changes and clears when read.
// - A set falling mask bit records a one-to-zero condition change.
// - A set rising mask bit records a zero-to-one condition change.
// - An enabled true event bit gives a positive summary transition upward.
// - Preset sets rising masks to ones, falling and enable masks to zero.
`ifndef SERG_DEFS_SVH
`define SERG_DEFS_SVH

// Width of every status part
`define SERG_WIDTH        15
// Width of the write data field, one bit above a part for range checks
`define SERG_WDATA_WIDTH  16
// Largest legal configuration value
`define SERG_VALUE_MAX    16'h7FFF

// Preset and reset values of the configuration parts
`define SERG_PTR_PRESET   15'h7FFF
`define SERG_NTR_PRESET   15'h0000
`define SERG_ENAB_PRESET  15'h0000
`define SERG_ZERO         15'h0000

// Part selector codes
`define SERG_PART_COND    3'h0
`define SERG_PART_ENAB    3'h1
`define SERG_PART_EVNT    3'h2
`define SERG_PART_NTR     3'h3
`define SERG_PART_PTR     3'h4

// Command codes
`define SERG_CMD_READ     2'h0
`define SERG_CMD_WRITE    2'h1
`define SERG_CMD_PRESET   2'h2
`define SERG_CMD_INSTRST  2'h3

// Group selector codes
`define SERG_GRP_OPER     1'h0
`define SERG_GRP_QUES     1'h1

`endif

// ### rtl/serg_pkg.sv
// Purpose: Types for the status event register group.
// Assumes: serg_defs.svh holds the numeric codes.
// Notes:   Enum values come from the header so each number lives once.
`include "serg_defs.svh"

package serg_pkg;

  typedef logic [`SERG_WIDTH-1:0]       serg_part_t;
  typedef logic [`SERG_WDATA_WIDTH-1:0] serg_wdata_t;

  typedef enum logic [1:0] {
    SERG_CMD_READ    = `SERG_CMD_READ,
    SERG_CMD_WRITE   = `SERG_CMD_WRITE,
    SERG_CMD_PRESET  = `SERG_CMD_PRESET,
    SERG_CMD_INSTRST = `SERG_CMD_INSTRST
  } serg_cmd_e;

  typedef enum logic [2:0] {
    SERG_PART_COND = `SERG_PART_COND,
    SERG_PART_ENAB = `SERG_PART_ENAB,
    SERG_PART_EVNT = `SERG_PART_EVNT,
    SERG_PART_NTR  = `SERG_PART_NTR,
    SERG_PART_PTR  = `SERG_PART_PTR
  } serg_part_e;

endpackage

// ### rtl/serg_reg_group.sv
// Purpose: One status register group: condition, filters, event, enable.
// Assumes: At most one strobe per cycle from the command decoder.
// Notes:   Condition inputs are asynchronous and pass three flip-flops.
`timescale 1ns/10ps
`include "serg_defs.svh"

module serg_reg_group #(
  parameter int W = `SERG_WIDTH
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] cond_in,
  input  wire logic         preset,
  input  wire logic         wr_enab,
  input  wire logic         wr_ntr,
  input  wire logic         wr_ptr,
  input  wire logic [W-1:0] wr_data,
  input  wire logic         rd_evt_clr,
  output logic      [W-1:0] cond_o,
  output logic      [W-1:0] enab_o,
  output logic      [W-1:0] evt_o,
  output logic      [W-1:0] ntr_o,
  output logic      [W-1:0] ptr_o,
  output logic              summary_o
);
  import serg_pkg::*;

  logic [W-1:0] sync1_r, sync2_r, sync3_r;
  logic [W-1:0] cond_r,  cond_nxt;
  logic [W-1:0] enab_r,  enab_nxt;
  logic [W-1:0] ntr_r,   ntr_nxt;
  logic [W-1:0] ptr_r,   ptr_nxt;
  logic [W-1:0] evt_r,   evt_nxt;
  logic [W-1:0] agree;
  logic [W-1:0] rise;
  logic [W-1:0] fall;

  // Condition follows the live inputs once two stages agree; reads never
  // touch it, so it always shows the present hardware state
  always_comb begin
    agree    = ~(sync2_r ^ sync3_r);
    cond_nxt = (sync2_r & agree) | (cond_r & ~agree);
    rise     = cond_nxt & ~cond_r;
    fall     = ~cond_nxt & cond_r;
  end

  // Configuration parts: preset wins over writes, writes are exclusive
  always_comb begin
    enab_nxt = enab_r;
    ntr_nxt  = ntr_r;
    ptr_nxt  = ptr_r;
    if (preset) begin
      ptr_nxt  = `SERG_PTR_PRESET;
      ntr_nxt  = `SERG_NTR_PRESET;
      enab_nxt = `SERG_ENAB_PRESET;
    end else begin
      if (wr_enab) enab_nxt = wr_data;
      if (wr_ntr)  ntr_nxt  = wr_data;
      if (wr_ptr)  ptr_nxt  = wr_data;
    end
  end

  // Event part: clear first, then new qualified edges, so a set wins
  always_comb begin
    evt_nxt = rd_evt_clr ? `SERG_ZERO : evt_r;
    evt_nxt = evt_nxt | (rise & ptr_r)
                      | (fall & ntr_r);
  end

  // State registers; reset only by rst_n, never by the instrument reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= `SERG_ZERO;
      sync2_r <= `SERG_ZERO;
      sync3_r <= `SERG_ZERO;
      cond_r  <= `SERG_ZERO;
      enab_r  <= `SERG_ENAB_PRESET;
      ntr_r   <= `SERG_NTR_PRESET;
      ptr_r   <= `SERG_PTR_PRESET;
      evt_r   <= `SERG_ZERO;
    end else begin
      sync1_r <= cond_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      cond_r  <= cond_nxt;
      enab_r  <= enab_nxt;
      ntr_r   <= ntr_nxt;
      ptr_r   <= ptr_nxt;
      evt_r   <= evt_nxt;
    end
  end

  assign cond_o    = cond_r;
  assign enab_o    = enab_r;
  assign evt_o     = evt_r;
  assign ntr_o     = ntr_r;
  assign ptr_o     = ptr_r;
  assign summary_o = |(evt_r & enab_r);

endmodule // serg_reg_group

// ### rtl/serg_top.sv
// Purpose: Status reporting block with operation and questionable groups.
// Assumes: One command per cycle on the command port, no back-pressure.
// Notes:   Every command answers exactly one cycle after it is taken.
//          Status parts change only by rst_n, the condition inputs, writes,
//          reads of the event part or the preset command; the instrument reset
//          command is acknowledged and touches nothing.
`timescale 1ns/10ps
`include "serg_defs.svh"

module serg_top #(
  parameter int W = `SERG_WIDTH
) (
  input  wire logic                sys_clk,
  input  wire logic                rst_n,
  // Live hardware activity, asynchronous to sys_clk
  input  wire logic [W-1:0]        oper_cond_in,
  input  wire logic [W-1:0]        ques_cond_in,
  // Command port
  input  wire logic                cmd_valid,
  input  wire serg_pkg::serg_cmd_e cmd_op,
  input  wire logic                cmd_group,
  input  wire logic [2:0]          cmd_part,
  input  wire serg_pkg::serg_wdata_t cmd_wdata,
  // Answer port
  output logic                     rsp_valid,
  output logic [W-1:0]             rsp_data,
  output logic                     rsp_error,
  // Summary bits of the status byte and their rising pulses
  output logic                     oper_summary,
  output logic                     ques_summary,
  output logic                     oper_summary_rise,
  output logic                     ques_summary_rise
);
  import serg_pkg::*;

  // Decoded strobes
  logic         is_read;
  logic         is_write;
  logic         is_preset;
  logic         is_instrst;
  logic         part_known;
  logic         part_writable;
  logic         value_ok;
  logic         wr_ok;
  logic         sel_oper;
  logic         sel_ques;
  logic         wr_enab_s;
  logic         wr_ntr_s;
  logic         wr_ptr_s;
  logic         rd_evt_s;
  logic [W-1:0] wr_val;

  // Group views
  logic [W-1:0] oper_cond, oper_enab, oper_evt, oper_ntr, oper_ptr;
  logic [W-1:0] ques_cond, ques_enab, ques_evt, ques_ntr, ques_ptr;
  logic         oper_sum_c;
  logic         ques_sum_c;
  logic [W-1:0] gcond, genab, gevt, gntr, gptr;

  // Answer and summary registers
  logic         rsp_valid_r, rsp_valid_nxt;
  logic [W-1:0] rsp_data_r,  rsp_data_nxt;
  logic         rsp_error_r, rsp_error_nxt;
  logic         oper_sum_r,  oper_sum_nxt;
  logic         ques_sum_r,  ques_sum_nxt;
  logic         oper_rise_r, oper_rise_nxt;
  logic         ques_rise_r, ques_rise_nxt;

  // Command decode; values above the legal range are refused, not cut,
  // so a host that sets bit 15 by mistake sees an error rather than a
  // silently different mask
  always_comb begin
    // Kind of command
    is_read    = cmd_valid && (cmd_op == SERG_CMD_READ);
    is_write   = cmd_valid && (cmd_op == SERG_CMD_WRITE);
    is_preset  = cmd_valid && (cmd_op == SERG_CMD_PRESET);
    is_instrst = cmd_valid && (cmd_op == SERG_CMD_INSTRST);
    // Part checks
    part_known = (cmd_part <= `SERG_PART_PTR);
    part_writable = (cmd_part == `SERG_PART_ENAB) ||
                    (cmd_part == `SERG_PART_NTR)  ||
                    (cmd_part == `SERG_PART_PTR);
    value_ok   = (cmd_wdata <= `SERG_VALUE_MAX);
    wr_ok      = is_write && part_writable && value_ok;
    // Group select and write strobes
    sel_oper   = (cmd_group == `SERG_GRP_OPER);
    sel_ques   = (cmd_group == `SERG_GRP_QUES);
    wr_enab_s  = wr_ok && (cmd_part == `SERG_PART_ENAB);
    wr_ntr_s   = wr_ok && (cmd_part == `SERG_PART_NTR);
    wr_ptr_s   = wr_ok && (cmd_part == `SERG_PART_PTR);
    rd_evt_s   = is_read && (cmd_part == `SERG_PART_EVNT);
    wr_val     = cmd_wdata[W-1:0];
  end

  // Operation group; instrument reset drives no strobe here
  // Preset reaches both groups at once, whatever the group bit says
  serg_reg_group #(
    .W (W)
  ) u_oper (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .cond_in    (oper_cond_in),
    .preset     (is_preset),
    .wr_enab    (wr_enab_s && sel_oper),
    .wr_ntr     (wr_ntr_s && sel_oper),
    .wr_ptr     (wr_ptr_s && sel_oper),
    .wr_data    (wr_val),
    .rd_evt_clr (rd_evt_s && sel_oper),
    .cond_o     (oper_cond),
    .enab_o     (oper_enab),
    .evt_o      (oper_evt),
    .ntr_o      (oper_ntr),
    .ptr_o      (oper_ptr),
    .summary_o  (oper_sum_c)
  );

  // Questionable group, same structure; a separate instance keeps
  // the event parts of the two groups fully independent
  serg_reg_group #(
    .W (W)
  ) u_ques (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .cond_in    (ques_cond_in),
    .preset     (is_preset),
    .wr_enab    (wr_enab_s && sel_ques),
    .wr_ntr     (wr_ntr_s && sel_ques),
    .wr_ptr     (wr_ptr_s && sel_ques),
    .wr_data    (wr_val),
    .rd_evt_clr (rd_evt_s && sel_ques),
    .cond_o     (ques_cond),
    .enab_o     (ques_enab),
    .evt_o      (ques_evt),
    .ntr_o      (ques_ntr),
    .ptr_o      (ques_ptr),
    .summary_o  (ques_sum_c)
  );

  // Pick the addressed group for read data
  // Preset and instrument reset ignore the selection
  always_comb begin
    gcond = sel_oper ? oper_cond : ques_cond;
    genab = sel_oper ? oper_enab : ques_enab;
    gevt  = sel_oper ? oper_evt  : ques_evt;
    gntr  = sel_oper ? oper_ntr  : ques_ntr;
    gptr  = sel_oper ? oper_ptr  : ques_ptr;
  end

  // Answer: event reads return the value held before this edge clears it,
  // so a bit that arrives in the same cycle shows in the next read
  // instead of being lost
  always_comb begin
    rsp_valid_nxt = cmd_valid;
    rsp_data_nxt  = `SERG_ZERO;
    rsp_error_nxt = 1'b0;
    if (is_read) begin
      case (cmd_part)
        `SERG_PART_COND: rsp_data_nxt = gcond;
        `SERG_PART_ENAB: rsp_data_nxt = genab;
        `SERG_PART_EVNT: rsp_data_nxt = gevt;
        `SERG_PART_NTR:  rsp_data_nxt = gntr;
        `SERG_PART_PTR:  rsp_data_nxt = gptr;
        default:         rsp_error_nxt = 1'b1;
      endcase
    end else if (is_write) begin
      // Condition and event parts are query only; a refused write
      // changes nothing in either group
      rsp_error_nxt = !(part_known && part_writable && value_ok);
    end else if (is_preset) begin
      // Masks of both groups return to their preset values
      rsp_error_nxt = 1'b0;
    end else if (is_instrst) begin
      // Acknowledged only; status parts keep their contents, so a
      // host can reset the instrument without losing pending events
      rsp_error_nxt = 1'b0;
    end
  end

  // Summary bits and their rising pulses for the next status level
  // The level follows the enabled events; the pulse lets the next level
  // latch a new cause without sampling the level every cycle
  always_comb begin
    oper_sum_nxt  = oper_sum_c;
    ques_sum_nxt  = ques_sum_c;
    oper_rise_nxt = oper_sum_c && !oper_sum_r;
    ques_rise_nxt = ques_sum_c && !ques_sum_r;
  end

  // Output registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid_r <= 1'b0;
      rsp_data_r  <= `SERG_ZERO;
      rsp_error_r <= 1'b0;
      oper_sum_r  <= 1'b0;
      ques_sum_r  <= 1'b0;
      oper_rise_r <= 1'b0;
      ques_rise_r <= 1'b0;
    end else begin
      rsp_valid_r <= rsp_valid_nxt;
      rsp_data_r  <= rsp_data_nxt;
      rsp_error_r <= rsp_error_nxt;
      oper_sum_r  <= oper_sum_nxt;
      ques_sum_r  <= ques_sum_nxt;
      oper_rise_r <= oper_rise_nxt;
      ques_rise_r <= ques_rise_nxt;
    end
  end

  // Answer ports straight from their flip-flops
  assign rsp_valid         = rsp_valid_r;
  assign rsp_data          = rsp_data_r;
  assign rsp_error         = rsp_error_r;

  // Summary levels and pulses for the next status level
  assign oper_summary      = oper_sum_r;
  assign ques_summary      = ques_sum_r;
  assign oper_summary_rise = oper_rise_r;
  assign ques_summary_rise = ques_rise_r;

endmodule // serg_top

// ### verification/serg_checker.sv
// Purpose: Port-level assertions for serg_top.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Summary lags an enable change by two edges.
`timescale 1ns/10ps
module serg_checker #(
  parameter int W = 15
) (
  input wire logic                   sys_clk,
  input wire logic                   rst_n,
  input wire logic                   cmd_valid,
  input wire serg_pkg::serg_cmd_e    cmd_op,
  input wire logic [2:0]             cmd_part,
  input wire serg_pkg::serg_wdata_t  cmd_wdata,
  input wire logic                   rsp_valid,
  input wire logic [W-1:0]           rsp_data,
  input wire logic                   rsp_error,
  input wire logic                   oper_summary,
  input wire logic                   ques_summary,
  input wire logic                   oper_summary_rise,
  input wire logic                   ques_summary_rise
);
  import serg_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Answers come exactly one edge after a command and never otherwise
  a_rsp_follows_cmd: assert property (cmd_valid |=> rsp_valid)
    else $error("command not answered");
  a_no_stray_rsp: assert property (rsp_valid |-> $past(cmd_valid))
    else $error("answer without command");
  // Out-of-range values and bad parts are refused with zero data
  a_big_value_refused: assert property (cmd_valid && cmd_op == SERG_CMD_WRITE
    && cmd_wdata[15] |=> rsp_error) else $error("large write taken");
  a_bad_part_refused: assert property (cmd_valid && cmd_part > 3'h4
    && (cmd_op == SERG_CMD_READ || cmd_op == SERG_CMD_WRITE)
    |=> rsp_error && rsp_data == '0) else $error("bad part taken");
  a_instrst_quiet: assert property (cmd_valid && cmd_op == SERG_CMD_INSTRST
    |=> !rsp_error && rsp_data == '0) else $error("reset cmd answer");
  // Preset zeroes the enables, so both summaries drop two edges on
  a_preset_summary: assert property (cmd_valid && cmd_op == SERG_CMD_PRESET
    |-> ##2 !oper_summary && !ques_summary) else $error("summary kept");
  // Rise pulses mark exactly the summary 0 to 1 step
  a_oper_rise_pulse: assert property (oper_summary_rise
    |-> oper_summary && !$past(oper_summary)) else $error("oper rise");
  a_ques_rise_seen: assert property ($rose(ques_summary)
    |-> ques_summary_rise) else $error("ques rise missing");
  a_rise_one_cycle: assert property (ques_summary_rise
    |=> !ques_summary_rise) else $error("rise pulse too long");
endmodule // serg_checker

bind serg_top serg_checker #(.W(W)) serg_checker_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
  .cmd_op(cmd_op), .cmd_part(cmd_part), .cmd_wdata(cmd_wdata),
  .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_error(rsp_error),
  .oper_summary(oper_summary), .ques_summary(ques_summary),
  .oper_summary_rise(oper_summary_rise),
  .ques_summary_rise(ques_summary_rise));

// ### verification/status_event_register_group_tb.sv
// Purpose: Self-checking bench for serg_top.
// Assumes: Inputs change on the falling edge; condition needs 4 edges.
// Notes:   Commands are spaced one idle cycle apart for clarity.
`timescale 1ns/10ps
module status_event_register_group_tb;
  import serg_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [14:0] oper_cond = '0;
  logic [14:0] ques_cond = '0;
  logic        cmd_valid = 1'b0;
  serg_cmd_e   cmd_op = SERG_CMD_READ;
  logic        cmd_group = 1'b0;
  logic [2:0]  cmd_part = 3'h0;
  serg_wdata_t cmd_wdata = '0;
  logic        rsp_valid, rsp_error, oper_sum, ques_sum, oper_rise, ques_rise;
  logic [14:0] rsp_data, rdata;
  logic        rerr;
  logic        rise_seen = 1'b0;
  logic        oper_rise_seen = 1'b0;
  int          fails = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  serg_top serg_top_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .oper_cond_in(oper_cond), .ques_cond_in(ques_cond),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_group(cmd_group),
    .cmd_part(cmd_part), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_error(rsp_error), .oper_summary(oper_sum),
    .ques_summary(ques_sum), .oper_summary_rise(oper_rise),
    .ques_summary_rise(ques_rise));

  // Clock and a hang guard well above the expected run
  always #4 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (ques_rise === 1'b1) rise_seen <= 1'b1;
    if (oper_rise === 1'b1) oper_rise_seen <= 1'b1;
    if (cyc == 5000) begin
      fails++;
      test_done();
    end
  end

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // One command, answer captured one edge after it is taken
  task automatic cmd(input serg_cmd_e op, input logic g, input logic [2:0] p,
                     input serg_wdata_t wd);
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_group = g;
    cmd_part = p;
    cmd_wdata = wd;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    rdata = rsp_data;
    rerr = rsp_error;
    chk({15'h0, rsp_valid}, 16'h1);
  endtask

  task automatic rd(input logic g, input logic [2:0] p, input logic [14:0] e);
    cmd(SERG_CMD_READ, g, p, 16'h0000);
    chk({rerr, rdata}, {1'b0, e});
  endtask

  task automatic wr(input logic g, input logic [2:0] p, input logic [14:0] v);
    cmd(SERG_CMD_WRITE, g, p, {1'b0, v});
    chk({15'h0, rerr}, 16'h0);
  endtask

  task automatic t_reset();
    rd(1'b0, SERG_PART_ENAB, 15'h0000);
    rd(1'b0, SERG_PART_NTR, 15'h0000);
    rd(1'b1, SERG_PART_PTR, 15'h7FFF);
    rd(1'b0, SERG_PART_EVNT, 15'h0000);
    $display("t_reset done");
  endtask

  task automatic t_cond();
    oper_cond = 15'h5A5A;
    wt(6);
    rd(1'b0, SERG_PART_COND, 15'h5A5A);
    rd(1'b0, SERG_PART_COND, 15'h5A5A);
    rd(1'b0, SERG_PART_EVNT, 15'h5A5A);
    rd(1'b0, SERG_PART_EVNT, 15'h0000);
    $display("t_cond done");
  endtask

  // Falls recorded only under the mask; zero masks record nothing
  task automatic t_fall();
    wr(1'b0, SERG_PART_NTR, 15'h000F);
    wr(1'b0, SERG_PART_PTR, 15'h0000);
    oper_cond = 15'h5A50;
    wt(6);
    rd(1'b0, SERG_PART_EVNT, 15'h000A);
    wr(1'b0, SERG_PART_NTR, 15'h0000);
    oper_cond = 15'h5A5A;
    wt(6);
    oper_cond = 15'h5A50;
    wt(6);
    rd(1'b0, SERG_PART_EVNT, 15'h0000);
    $display("t_fall done");
  endtask

  task automatic t_summary();
    wr(1'b1, SERG_PART_ENAB, 15'h0002);
    ques_cond = 15'h0001;
    wt(6);
    chk({15'h0, ques_sum}, 16'h0);
    wr(1'b1, SERG_PART_ENAB, 15'h0001);
    wt(3);
    chk({15'h0, ques_sum}, 16'h1);
    chk({15'h0, rise_seen}, 16'h1);
    rd(1'b1, SERG_PART_EVNT, 15'h0001);
    wt(3);
    chk({15'h0, ques_sum}, 16'h0);
    // Rise of bit 1 lands on the edge that takes the clearing read
    ques_cond = 15'h0003;
    wt(2);
    rd(1'b1, SERG_PART_EVNT, 15'h0000);
    rd(1'b1, SERG_PART_EVNT, 15'h0002);
    $display("t_summary done");
  endtask

  task automatic t_refuse();
    cmd(SERG_CMD_WRITE, 1'b0, SERG_PART_ENAB, 16'h8000);
    chk({15'h0, rerr}, 16'h1);
    cmd(SERG_CMD_WRITE, 1'b0, SERG_PART_COND, 16'h0001);
    chk({15'h0, rerr}, 16'h1);
    cmd(SERG_CMD_READ, 1'b0, 3'h5, 16'h0000);
    chk({rerr, rdata}, 16'h8000);
    rd(1'b0, SERG_PART_ENAB, 15'h0000);
    wr(1'b0, SERG_PART_ENAB, 15'h7FFF);
    rd(1'b0, SERG_PART_ENAB, 15'h7FFF);
    chk({15'h0, oper_rise_seen}, 16'h0);
    $display("t_refuse done");
  endtask

  // Instrument reset keeps state; preset restores the masks
  task automatic t_preset();
    wr(1'b1, SERG_PART_NTR, 15'h1234);
    wr(1'b0, SERG_PART_PTR, 15'h7FFF);
    oper_cond = 15'h5A5F;
    wt(6);
    chk({15'h0, oper_sum}, 16'h1);
    chk({15'h0, oper_rise_seen}, 16'h1);
    cmd(SERG_CMD_INSTRST, 1'b0, 3'h0, 16'h0000);
    chk({15'h0, rerr}, 16'h0);
    rd(1'b1, SERG_PART_NTR, 15'h1234);
    rd(1'b0, SERG_PART_ENAB, 15'h7FFF);
    cmd(SERG_CMD_PRESET, 1'b0, 3'h0, 16'h0000);
    chk({15'h0, rerr}, 16'h0);
    rd(1'b1, SERG_PART_NTR, 15'h0000);
    rd(1'b0, SERG_PART_PTR, 15'h7FFF);
    rd(1'b0, SERG_PART_ENAB, 15'h0000);
    rd(1'b1, SERG_PART_ENAB, 15'h0000);
    chk({15'h0, oper_sum}, 16'h0);
    rd(1'b0, SERG_PART_EVNT, 15'h000F);
    $display("t_preset done");
  endtask

  // Reset for 20 cycles, then the scenarios in turn
  initial begin
    wt(20);
    rst_n = 1'b1;
    t_reset();
    t_cond();
    t_fall();
    t_summary();
    t_refuse();
    t_preset();
    test_done();
  end
endmodule // status_event_register_group_tb
